// [debug_port_params.svh]
`ifndef DEBUG_PORT_PARAMS_SVH
`define DEBUG_PORT_PARAMS_SVH

// Register selector values seen on the link
`define ADDR_DEVICE_IDENTITY     8'h00
`define ADDR_SILICON_REVISION    8'h01
`define ADDR_PROGRAMMING_CONTROL 8'h02
`define ADDR_PROGRAMMING_DATA    8'hb4

// Reset values
`define RESET_ADDRESS_SELECT     8'h00
`define RESET_PROGRAMMING_CTRL   8'h00
`define RESET_PROGRAMMING_DATA   8'h00
`define RESET_UNMAPPED_READ      8'h00

// Unlock sequence codes, first then second
`define UNLOCK_FIRST_CODE        8'h02
`define UNLOCK_SECOND_CODE       8'h01

// Flash command bytes
`define CMD_BLOCK_READ           8'h06
`define CMD_BLOCK_WRITE          8'h07
`define CMD_PAGE_ERASE           8'h08
`define CMD_DEVICE_ERASE         8'h03

// Link instruction codes, sent low bit first after the start bit
`define INS_DATA_READ            2'h0
`define INS_DATA_WRITE           2'h1
`define INS_ADDR_READ            2'h2
`define INS_ADDR_WRITE           2'h3

// Bits in one link byte
`define LINK_BYTE_BITS           4'h8

`endif

// [debug_port_pkg.sv]
package debug_port_pkg;

	typedef enum logic [2:0] {
		LINK_IDLE  = 3'b000,
		LINK_INS0  = 3'b001,
		LINK_INS1  = 3'b010,
		LINK_WDATA = 3'b011,
		LINK_WAIT  = 3'b100,
		LINK_RDATA = 3'b101
	} link_state_t;

	typedef enum logic [1:0] {
		UNLOCK_LOCKED  = 2'b00,
		UNLOCK_ARMED   = 2'b01,
		UNLOCK_ENABLED = 2'b10
	} unlock_state_t;

	typedef enum logic [2:0] {
		FLASH_CMD_NONE         = 3'b000,
		FLASH_CMD_BLOCK_READ   = 3'b001,
		FLASH_CMD_BLOCK_WRITE  = 3'b010,
		FLASH_CMD_PAGE_ERASE   = 3'b011,
		FLASH_CMD_DEVICE_ERASE = 3'b100
	} flash_cmd_t;

endpackage

// [link_serial_engine.sv]
`timescale 1ns/1ps
`include "debug_port_params.svh"

// Serial side of the debug port, clocked by the host's link clock
module link_serial_engine (
	input  wire logic       debug_link_clock,
	input  wire logic       rst,
	input  wire logic       debug_link_data_in,
	output logic            debug_link_data_out,
	output logic            debug_link_data_oe,
	input  wire logic       halted_level,
	output logic            req_toggle,
	output logic            req_write,
	output logic [7:0]      req_addr,
	output logic [7:0]      req_wdata,
	input  wire logic       ack_toggle,
	input  wire logic [7:0] ack_rdata
);

	debug_port_pkg::link_state_t state, next_state;
	logic       halted_s1, halted_s2, ack_s1, ack_s2;
	logic [1:0] ins, next_ins;
	logic [7:0] shift, next_shift;
	logic [3:0] count, next_count;
	logic [7:0] next_addr, next_wdata;
	logic       next_req_toggle, next_req_write, next_out, next_oe;

	// Two-stage synchronisers for the halt level and the answer toggle
	always_ff @(posedge debug_link_clock or posedge rst) begin
		if (rst) begin
			halted_s1 <= 1'b0;
			halted_s2 <= 1'b0;
			ack_s1    <= 1'b0;
			ack_s2    <= 1'b0;
		end else begin
			halted_s1 <= halted_level;
			halted_s2 <= halted_s1;
			ack_s1    <= ack_toggle;
			ack_s2    <= ack_s1;
		end
	end

	// Frame decoder; a frame only starts while the core is halted
	always_comb begin
		next_state      = state;
		next_ins        = ins;
		next_shift      = shift;
		next_count      = count;
		next_addr       = req_addr;
		next_wdata      = req_wdata;
		next_req_toggle = req_toggle;
		next_req_write  = req_write;
		next_out        = 1'b0;
		next_oe         = 1'b0;
		case (state)
			debug_port_pkg::LINK_IDLE: begin
				if (halted_s2 && debug_link_data_in) begin
					next_state = debug_port_pkg::LINK_INS0;
				end
			end
			debug_port_pkg::LINK_INS0: begin
				next_ins[0] = debug_link_data_in;
				next_state  = debug_port_pkg::LINK_INS1;
			end
			debug_port_pkg::LINK_INS1: begin
				next_ins[1] = debug_link_data_in;
				next_count  = 4'h0;
				if ({debug_link_data_in, ins[0]} == `INS_DATA_READ) begin
					next_req_write  = 1'b0;
					next_req_toggle = ~req_toggle;
					next_state      = debug_port_pkg::LINK_WAIT;
				end else if ({debug_link_data_in, ins[0]} == `INS_ADDR_READ) begin
					next_shift = req_addr;
					next_state = debug_port_pkg::LINK_RDATA;
				end else begin
					next_state = debug_port_pkg::LINK_WDATA;
				end
			end
			debug_port_pkg::LINK_WDATA: begin
				next_shift = {debug_link_data_in, shift[7:1]};
				next_count = count + 4'h1;
				if (next_count == `LINK_BYTE_BITS) begin
					next_count = 4'h0;
					if (ins == `INS_ADDR_WRITE) begin
						next_addr  = next_shift;
						next_state = debug_port_pkg::LINK_IDLE;
					end else begin
						next_wdata      = next_shift;
						next_req_write  = 1'b1;
						next_req_toggle = ~req_toggle;
						next_state      = debug_port_pkg::LINK_WAIT;
					end
				end
			end
			debug_port_pkg::LINK_WAIT: begin
				// Drive low until the system side answers, then one high ready bit
				next_oe  = 1'b1;
				next_out = (ack_s2 == req_toggle);
				if (ack_s2 == req_toggle) begin
					next_shift = ack_rdata; // Stable: only changes on a new request
					next_state = req_write ? debug_port_pkg::LINK_IDLE : debug_port_pkg::LINK_RDATA;
				end
			end
			debug_port_pkg::LINK_RDATA: begin
				next_oe    = 1'b1;
				next_out   = shift[0];
				next_shift = {1'b0, shift[7:1]};
				next_count = count + 4'h1;
				if (next_count == `LINK_BYTE_BITS) begin
					next_count = 4'h0;
					next_state = debug_port_pkg::LINK_IDLE;
				end
			end
			default: next_state = debug_port_pkg::LINK_IDLE;
		endcase
	end

	always_ff @(posedge debug_link_clock or posedge rst) begin
		if (rst) begin
			state               <= debug_port_pkg::LINK_IDLE;
			ins                 <= 2'h0;
			shift               <= 8'h00;
			count               <= 4'h0;
			req_addr            <= `RESET_ADDRESS_SELECT;
			req_wdata           <= 8'h00;
			req_toggle          <= 1'b0;
			req_write           <= 1'b0;
			debug_link_data_out <= 1'b0;
			debug_link_data_oe  <= 1'b0;
		end else begin
			state               <= next_state;
			ins                 <= next_ins;
			shift               <= next_shift;
			count               <= next_count;
			req_addr            <= next_addr;
			req_wdata           <= next_wdata;
			req_toggle          <= next_req_toggle;
			req_write           <= next_req_write;
			debug_link_data_out <= next_out;
			debug_link_data_oe  <= next_oe;
		end
	end

endmodule // link_serial_engine

// [two_wire_flash_prog_regs.sv]
`timescale 1ns/1ps
`include "debug_port_params.svh"

module two_wire_flash_prog_regs #(
	parameter logic [7:0] DEVICE_IDENTITY  = 8'h5c, // Arbitrary value
	parameter logic [7:0] SILICON_REVISION = 8'h0c  // Arbitrary value
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        debug_link_clock,
	input  wire logic                        debug_link_data_in,
	output logic                             debug_link_data_out,
	output logic                             debug_link_data_oe,
	input  wire logic                        device_halted,
	output logic                             pin_borrowed,
	output logic                             program_enable,
	output logic [7:0]                       programming_data,
	output logic                             prog_data_written,
	output logic                             prog_data_read,
	output debug_port_pkg::flash_cmd_t       flash_cmd,
	output logic                             flash_cmd_valid,
	input  wire logic                        flash_cmd_expected,
	input  wire logic                        flash_read_valid,
	input  wire logic [7:0]                  flash_read_byte
);

	// Crossing signals owned by the link side; frozen while a request is pending
	logic                          req_toggle;
	logic                          req_write;
	logic [7:0]                    req_addr;
	logic [7:0]                    req_wdata;

	// Crossing signals owned by the system side; the byte settles before the toggle is seen
	logic                          ack_toggle;
	logic                          next_ack_toggle;
	logic [7:0]                    ack_rdata;
	logic [7:0]                    next_ack_rdata;

	// Request toggle synchroniser stages and the strobe they produce
	logic                          req_s1;
	logic                          req_s2;
	logic                          req_s3;
	logic                          req_event;

	// Unlock sequencer
	debug_port_pkg::unlock_state_t unlock;
	debug_port_pkg::unlock_state_t next_unlock;

	// Register contents and their next values
	logic [7:0]                    programming_control;
	logic [7:0]                    next_programming_control;
	logic [7:0]                    next_programming_data;
	logic                          next_prog_data_written;
	logic                          next_prog_data_read;
	logic                          next_flash_cmd_valid;
	debug_port_pkg::flash_cmd_t    next_flash_cmd;

	link_serial_engine u_link (
		.debug_link_clock    (debug_link_clock),
		.rst                 (rst),
		.debug_link_data_in  (debug_link_data_in),
		.debug_link_data_out (debug_link_data_out),
		.debug_link_data_oe  (debug_link_data_oe),
		.halted_level        (pin_borrowed),
		.req_toggle          (req_toggle),
		.req_write           (req_write),
		.req_addr            (req_addr),
		.req_wdata           (req_wdata),
		.ack_toggle          (ack_toggle),
		.ack_rdata           (ack_rdata)
	);

	// Halt level registered so the link side synchronises a clean flop
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_borrowed <= 1'b0;
		end else begin
			pin_borrowed <= device_halted;
		end
	end

	// Request toggle synchroniser; the third stage feeds the edge detect
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req_toggle;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	// One strobe per link request; only settled stages are compared
	assign req_event = req_s2 ^ req_s3;

	// Command byte decode
	function automatic debug_port_pkg::flash_cmd_t decode_cmd(input logic [7:0] code);
		if (code == `CMD_BLOCK_READ) begin
			decode_cmd = debug_port_pkg::FLASH_CMD_BLOCK_READ;
		end else if (code == `CMD_BLOCK_WRITE) begin
			decode_cmd = debug_port_pkg::FLASH_CMD_BLOCK_WRITE;
		end else if (code == `CMD_PAGE_ERASE) begin
			decode_cmd = debug_port_pkg::FLASH_CMD_PAGE_ERASE;
		end else if (code == `CMD_DEVICE_ERASE) begin
			decode_cmd = debug_port_pkg::FLASH_CMD_DEVICE_ERASE;
		end else begin
			// Unknown bytes decode to none so a stray data byte never starts a flash operation
			decode_cmd = debug_port_pkg::FLASH_CMD_NONE;
		end
	endfunction

	// Register file: request/answer handshake, unlock sequence, data channel.
	// Request fields stay frozen until the answer toggles back, so they are read here directly.
	always_comb begin
		next_ack_toggle          = ack_toggle;
		next_ack_rdata           = ack_rdata;
		next_unlock              = unlock;
		next_programming_control = programming_control;
		next_programming_data    = programming_data;
		next_prog_data_written   = 1'b0;
		next_prog_data_read      = 1'b0;
		next_flash_cmd           = flash_cmd;
		next_flash_cmd_valid     = 1'b0;
		// Flash engine answers land first so a host write in the same cycle wins
		if (flash_read_valid && unlock == debug_port_pkg::UNLOCK_ENABLED) begin
			next_programming_data = flash_read_byte;
		end
		if (req_event) begin
			// Echo the synchronised level; the link side compares it with its own toggle
			next_ack_toggle = req_s2;
			if (req_write) begin
				// Writes: the control byte also steps the unlock sequencer
				if (req_addr == `ADDR_PROGRAMMING_CONTROL) begin
					next_programming_control = req_wdata;
					case (unlock)
						debug_port_pkg::UNLOCK_LOCKED: begin
							if (req_wdata == `UNLOCK_FIRST_CODE) begin
								next_unlock = debug_port_pkg::UNLOCK_ARMED;
							end
						end
						debug_port_pkg::UNLOCK_ARMED: begin
							// A repeated first code keeps the sequence armed; any byte other than the two codes disarms
							if (req_wdata == `UNLOCK_SECOND_CODE) begin
								next_unlock = debug_port_pkg::UNLOCK_ENABLED;
							end else if (req_wdata != `UNLOCK_FIRST_CODE) begin
								next_unlock = debug_port_pkg::UNLOCK_LOCKED;
							end
						end
						// Only a system reset leaves the enabled state
						default: next_unlock = debug_port_pkg::UNLOCK_ENABLED;
					endcase
				end else if (req_addr == `ADDR_PROGRAMMING_DATA) begin
					// Byte is kept even while locked so it reads back; side effects need the unlock
					next_programming_data = req_wdata;
					if (unlock == debug_port_pkg::UNLOCK_ENABLED) begin
						next_prog_data_written = 1'b1;
						// Only a byte that the flash engine asked for is taken as a command
						if (flash_cmd_expected) begin
							next_flash_cmd       = decode_cmd(req_wdata);
							next_flash_cmd_valid = 1'b1;
						end
					end
				end
				// Identity and revision writes fall through untouched
			end else begin
				// Reads: the answer byte stays frozen until the next request
				if (req_addr == `ADDR_DEVICE_IDENTITY) begin
					next_ack_rdata = DEVICE_IDENTITY;
				end else if (req_addr == `ADDR_SILICON_REVISION) begin
					next_ack_rdata = SILICON_REVISION;
				end else if (req_addr == `ADDR_PROGRAMMING_CONTROL) begin
					next_ack_rdata = programming_control;
				end else if (req_addr == `ADDR_PROGRAMMING_DATA) begin
					next_ack_rdata      = programming_data;
					next_prog_data_read = (unlock == debug_port_pkg::UNLOCK_ENABLED);
				end else begin
					// Unmapped selectors read as a fixed byte
					next_ack_rdata = `RESET_UNMAPPED_READ;
				end
			end
		end
	end

	// System side registers; enable follows the next unlock state so it rises with it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_toggle          <= 1'b0;
			ack_rdata           <= 8'h00;
			unlock              <= debug_port_pkg::UNLOCK_LOCKED;
			programming_control <= `RESET_PROGRAMMING_CTRL;
			programming_data    <= `RESET_PROGRAMMING_DATA;
			prog_data_written   <= 1'b0;
			prog_data_read      <= 1'b0;
			flash_cmd           <= debug_port_pkg::FLASH_CMD_NONE;
			flash_cmd_valid     <= 1'b0;
			program_enable      <= 1'b0;
		end else begin
			ack_toggle          <= next_ack_toggle;
			ack_rdata           <= next_ack_rdata;
			unlock              <= next_unlock;
			programming_control <= next_programming_control;
			programming_data    <= next_programming_data;
			prog_data_written   <= next_prog_data_written;
			prog_data_read      <= next_prog_data_read;
			flash_cmd           <= next_flash_cmd;
			flash_cmd_valid     <= next_flash_cmd_valid;
			program_enable      <= (next_unlock == debug_port_pkg::UNLOCK_ENABLED);
		end
	end

endmodule // two_wire_flash_prog_regs

// [two_wire_flash_prog_regs_monitor.sv]
`timescale 1ns/1ps
// Watches the system-side ports of the debug register block
module two_wire_flash_prog_regs_monitor (
	input wire logic                       sys_clk,
	input wire logic                       rst,
	input wire logic                       device_halted,
	input wire logic                       pin_borrowed,
	input wire logic                       program_enable,
	input wire logic [7:0]                 programming_data,
	input wire logic                       prog_data_written,
	input wire logic                       prog_data_read,
	input wire debug_port_pkg::flash_cmd_t flash_cmd,
	input wire logic                       flash_cmd_valid,
	input wire logic                       flash_cmd_expected,
	input wire logic                       flash_read_valid,
	input wire logic [7:0]                 flash_read_byte,
	input wire logic                       debug_link_data_oe
);
	// All checks live in the system clock domain
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_borrow_follows_halt: assert property ($rose(device_halted) |=> pin_borrowed)
		else $error("pin not borrowed after halt");
	a_enable_stays_set: assert property (program_enable |=> program_enable)
		else $error("programming mode left without reset");
	a_write_needs_enable: assert property (prog_data_written |-> program_enable)
		else $error("data write pulse while locked");
	a_read_needs_enable: assert property (prog_data_read |-> program_enable)
		else $error("data read pulse while locked");
	a_write_pulse_single: assert property (prog_data_written |=> !prog_data_written)
		else $error("data write pulse too long");
	a_cmd_needs_expect: assert property (flash_cmd_valid |-> program_enable && $past(flash_cmd_expected))
		else $error("command decoded when not expected");
	a_cmd_change_flagged: assert property (!$stable(flash_cmd) |-> flash_cmd_valid)
		else $error("command changed without valid");
	// A host write in the same cycle wins over the flash byte
	a_flash_byte_loads: assert property (flash_read_valid && program_enable |=>
		prog_data_written || programming_data == $past(flash_read_byte))
		else $error("flash byte not loaded");
	// The data pin must stay released while the pins are not borrowed
	a_oe_quiet_unhalted: assert property (!pin_borrowed |-> !debug_link_data_oe)
		else $error("data pin driven while running");
endmodule // two_wire_flash_prog_regs_monitor

bind two_wire_flash_prog_regs two_wire_flash_prog_regs_monitor i_two_wire_flash_prog_regs_monitor (
	.sys_clk(sys_clk), .rst(rst), .device_halted(device_halted), .pin_borrowed(pin_borrowed),
	.program_enable(program_enable), .programming_data(programming_data),
	.prog_data_written(prog_data_written), .prog_data_read(prog_data_read), .flash_cmd(flash_cmd),
	.flash_cmd_valid(flash_cmd_valid), .flash_cmd_expected(flash_cmd_expected),
	.flash_read_valid(flash_read_valid), .flash_read_byte(flash_read_byte),
	.debug_link_data_oe(debug_link_data_oe)
);

// [host_link_model.sv]
`timescale 1ns/1ps
// Host adapter; its clock runs only inside frames or bench-driven ticks and parks low between them
module host_link_model (
	output logic      debug_link_clock,
	output wire logic debug_link_data_in,
	input  wire logic debug_link_data_out,
	input  wire logic debug_link_data_oe
);
	logic drive_en = 1'b0;
	logic drive_val = 1'b0;
	// Released line shows the flipped last level so a stale bit never looks valid
	assign debug_link_data_in = drive_en ? drive_val : (debug_link_data_oe ? debug_link_data_out : ~drive_val);
	initial debug_link_clock = 1'b0;

	// One 125 ns link period, bit launched while the clock is low
	task automatic tick(input logic en, input logic val);
		drive_en = en;
		drive_val = en ? val : drive_val;
		#62.5 debug_link_clock = 1'b1;
		#62.5 debug_link_clock = 1'b0;
	endtask

	// Start, instruction bits low first, byte low first, wait for ready; ok low if none
	task automatic frame(input logic [1:0] ins, input logic [7:0] wr, output logic [7:0] rd, output logic ok);
		int i;
		ok = 1'b1;
		rd = 8'h00;
		tick(1'b1, 1'b1);
		for (i = 0; i < 2; i++) tick(1'b1, ins[i]);
		if (ins[0]) for (i = 0; i < 8; i++) tick(1'b1, wr[i]);
		if (!ins[1]) begin
			ok = 1'b0;
			// Keep clocking through the wait; bounded so an ignored frame ends
			for (i = 0; i < 40 && !ok; i++) begin
				tick(1'b0, 1'b0);
				ok = debug_link_data_oe && debug_link_data_out;
			end
		end
		if (!ins[0]) for (i = 0; i < 8; i++) begin
			tick(1'b0, 1'b0);
			rd[i] = debug_link_data_out;
		end
		tick(1'b1, 1'b0); // Low trailing bit so idle never sees a start
	endtask
endmodule // host_link_model

// [two_wire_flash_prog_regs_bench.sv]
`timescale 1ns/1ps
`include "debug_port_params.svh"
// Runs host frames against the block and checks system-side results
module two_wire_flash_prog_regs_bench;
	localparam logic [7:0] IDENT = 8'h5c; // Arbitrary value
	localparam logic [7:0] REV   = 8'h0c; // Arbitrary value
	// The last byte is no command and must decode to none
	localparam logic [7:0] CMDS [5] = '{`CMD_BLOCK_READ, `CMD_BLOCK_WRITE, `CMD_PAGE_ERASE, `CMD_DEVICE_ERASE, 8'h05};
	logic                       sys_clk, rst, link_clk, din, dout, doe, device_halted, pin_borrowed;
	logic                       program_enable, prog_data_written, prog_data_read, flash_cmd_valid;
	logic                       flash_cmd_expected, flash_read_valid, ok;
	logic [7:0]                 programming_data, flash_read_byte, v;
	logic [15:0]                seed;
	debug_port_pkg::flash_cmd_t flash_cmd;
	int                         error_cnt = 0, check_count = 0, wr_cnt = 0, rd_cnt = 0, cmd_cnt = 0;

	two_wire_flash_prog_regs #(.DEVICE_IDENTITY(IDENT), .SILICON_REVISION(REV)) i_two_wire_flash_prog_regs (
		.sys_clk(sys_clk), .rst(rst), .debug_link_clock(link_clk), .debug_link_data_in(din),
		.debug_link_data_out(dout), .debug_link_data_oe(doe), .device_halted(device_halted),
		.pin_borrowed(pin_borrowed), .program_enable(program_enable), .programming_data(programming_data),
		.prog_data_written(prog_data_written), .prog_data_read(prog_data_read), .flash_cmd(flash_cmd),
		.flash_cmd_valid(flash_cmd_valid), .flash_cmd_expected(flash_cmd_expected),
		.flash_read_valid(flash_read_valid), .flash_read_byte(flash_read_byte));
	host_link_model i_host_link_model (.debug_link_clock(link_clk), .debug_link_data_in(din),
		.debug_link_data_out(dout), .debug_link_data_oe(doe));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Count one-cycle pulses as they pass
	always @(posedge sys_clk) begin
		wr_cnt += (prog_data_written === 1'b1);
		rd_cnt += (prog_data_read === 1'b1);
		cmd_cnt += (flash_cmd_valid === 1'b1);
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic debug_port_pkg::flash_cmd_t cmd_of(input logic [7:0] b);
		case (b)
			`CMD_BLOCK_READ: return debug_port_pkg::FLASH_CMD_BLOCK_READ;
			`CMD_BLOCK_WRITE: return debug_port_pkg::FLASH_CMD_BLOCK_WRITE;
			`CMD_PAGE_ERASE: return debug_port_pkg::FLASH_CMD_PAGE_ERASE;
			`CMD_DEVICE_ERASE: return debug_port_pkg::FLASH_CMD_DEVICE_ERASE;
			default: return debug_port_pkg::FLASH_CMD_NONE;
		endcase
	endfunction
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host_link_model.frame(`INS_ADDR_WRITE, a, v, ok);
		i_host_link_model.frame(`INS_DATA_WRITE, d, v, ok);
		chk8("write ready", 8'h01, {7'h00, ok});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_host_link_model.frame(`INS_ADDR_WRITE, a, v, ok);
		i_host_link_model.frame(`INS_DATA_READ, 8'h00, v, ok);
		chk8("read data", exp, v);
	endtask
	// Link edges with the line low so the halt reaches the link domain
	task automatic sync_link();
		repeat (3) i_host_link_model.tick(1'b1, 1'b0);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		device_halted = 1'b0;
		flash_cmd_expected = 1'b0;
		flash_read_valid = 1'b0;
		flash_read_byte = 8'h00;
		seed = 16'h33a3;
		repeat (3) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk8("enable after reset", 8'h00, {7'h00, program_enable});
		i_host_link_model.frame(`INS_DATA_READ, 8'h00, v, ok);
		chk8("ready while running", 8'h00, {7'h00, ok});
		$display("test running frame done");
		@(posedge sys_clk) #1 device_halted = 1'b1;
		repeat (2) @(posedge sys_clk);
		chk8("pin borrowed", 8'h01, {7'h00, pin_borrowed});
		sync_link();
		i_host_link_model.frame(`INS_DATA_READ, 8'h00, v, ok);
		chk8("identity at selector zero", IDENT, v);
		seed = lfsr(seed);
		wr(`ADDR_DEVICE_IDENTITY, seed[7:0]);
		rd(`ADDR_DEVICE_IDENTITY, IDENT);
		wr(`ADDR_SILICON_REVISION, seed[15:8]);
		rd(`ADDR_SILICON_REVISION, REV);
		rd(8'h33, `RESET_UNMAPPED_READ);
		wr(`ADDR_PROGRAMMING_DATA, seed[7:0]);
		rd(`ADDR_PROGRAMMING_DATA, seed[7:0]);
		$display("test fixed registers done");
		wr(`ADDR_PROGRAMMING_CONTROL, 8'h01);
		wr(`ADDR_PROGRAMMING_CONTROL, 8'h02);
		wr(`ADDR_PROGRAMMING_CONTROL, 8'h05);
		chk8("enable after bad order", 8'h00, {7'h00, program_enable});
		chk8("locked pulses", 8'h00, 8'(wr_cnt + rd_cnt));
		wr(`ADDR_PROGRAMMING_CONTROL, `UNLOCK_FIRST_CODE);
		wr(`ADDR_PROGRAMMING_CONTROL, `UNLOCK_SECOND_CODE);
		chk8("enable after unlock", 8'h01, {7'h00, program_enable});
		rd(`ADDR_PROGRAMMING_CONTROL, `UNLOCK_SECOND_CODE);
		$display("test unlock done");
		@(posedge sys_clk) #1 flash_cmd_expected = 1'b1;
		for (int i = 0; i < 5; i++) begin
			wr(`ADDR_PROGRAMMING_DATA, CMDS[i]);
			chk8("flash command", {5'h00, cmd_of(CMDS[i])}, {5'h00, flash_cmd});
		end
		chk8("command pulses", 8'h05, 8'(cmd_cnt));
		@(posedge sys_clk) #1 flash_cmd_expected = 1'b0;
		repeat (4) begin
			seed = lfsr(seed);
			wr(`ADDR_PROGRAMMING_DATA, seed[7:0]);
			rd(`ADDR_PROGRAMMING_DATA, seed[7:0]);
		end
		i_host_link_model.frame(`INS_ADDR_READ, 8'h00, v, ok);
		chk8("selector readback", `ADDR_PROGRAMMING_DATA, v);
		chk8("write pulses", 8'h09, 8'(wr_cnt));
		chk8("read pulses", 8'h04, 8'(rd_cnt));
		@(posedge sys_clk) #1 flash_read_byte = seed[15:8];
		flash_read_valid = 1'b1;
		@(posedge sys_clk) #1 flash_read_valid = 1'b0;
		rd(`ADDR_PROGRAMMING_DATA, seed[15:8]);
		$display("test flash traffic done");
		chk8("enable held", 8'h01, {7'h00, program_enable});
		@(posedge sys_clk) #1 rst = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk8("enable after system reset", 8'h00, {7'h00, program_enable});
		sync_link();
		rd(`ADDR_PROGRAMMING_CONTROL, `RESET_PROGRAMMING_CTRL);
		$display("test system reset done");
		stop_test();
	end

	// Frames take a few microseconds each; this bound is far beyond the whole run
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		stop_test();
	end
endmodule // two_wire_flash_prog_regs_bench
